// ---- rtl/pwm_match_interrupt_logic.sv ----
/*
 * interrupt enable and flag logic of one pwm channel, apb slave.
 * assumes match strobes are one-cycle pulses from the pwm core on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_irq_cfg.svh"

module pwm_match_interrupt_logic (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`PWM_ADDR_W-1:0]   paddr,
	input  wire logic [`PWM_DATA_W-1:0]   pwdata,
	input  wire logic [3:0]               pstrb,
	output var  logic [`PWM_DATA_W-1:0]   prdata,
	output var  logic                     pready,
	output var  logic                     pslverr,
	input  wire pwm_irq_pkg::match_bits_s match_event,
	output var  logic                     module_enable,
	output var  pwm_irq_pkg::match_bits_s match_flags,
	output var  logic                     irq
);

	import pwm_irq_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// bus decode

	logic        access;
	logic        setup;
	logic        hit_enable;
	logic        hit_flags;
	logic        hit_ctrl;
	logic        mapped;
	logic        wr_lane0;
	match_bits_s irq_enable;
	match_bits_s flag_write;

	assign setup      = psel & ~penable;
	assign access     = psel & penable;
	assign hit_enable = (paddr == `PWM_OFF_ENABLE);
	assign hit_flags  = (paddr == `PWM_OFF_FLAGS);
	assign hit_ctrl   = (paddr == `PWM_OFF_CTRL);
	assign mapped     = hit_enable | hit_flags | hit_ctrl;
	assign wr_lane0   = access & pwrite & pstrb[0] & mapped;

	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	////////////////////////////////////////////////////////////////////////////
	// enable and control registers

	match_bits_s next_irq_enable;
	logic        next_module_enable;

	always_comb begin
		next_irq_enable    = irq_enable;
		next_module_enable = module_enable;
		if (wr_lane0 && hit_enable) begin
			next_irq_enable = match_bits_s'(pwdata[`PWM_FLAG_N-1:0]);
		end
		if (wr_lane0 && hit_ctrl) begin
			next_module_enable = pwdata[`PWM_BIT_MODULE_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable    <= match_bits_s'(`PWM_RST_FLAGS);
			module_enable <= 1'b0;
		end else begin
			irq_enable    <= next_irq_enable;
			module_enable <= next_module_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky flags

	logic                  flag_wr_en;
	logic [`PWM_FLAG_N-1:0] flag_vec;
	logic [`PWM_FLAG_N-1:0] event_vec;
	logic [`PWM_FLAG_N-1:0] write_vec;

	assign flag_wr_en  = wr_lane0 & hit_flags;
	assign flag_write  = match_bits_s'(pwdata[`PWM_FLAG_N-1:0]);
	assign event_vec   = match_event;
	assign write_vec   = flag_write;
	assign match_flags = match_bits_s'(flag_vec);

	genvar gi;
	generate
		for (gi = 0; gi < `PWM_FLAG_N; gi++) begin : g_flag
			sticky_flag u_flag (
				.pclk        (pclk),
				.presetn     (presetn),
				.hold_clear  (~module_enable),
				.set_event   (event_vec[gi]),
				.write_en    (flag_wr_en),
				.write_value (write_vec[gi]),
				.flag        (flag_vec[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// interrupt request

	assign irq = (match_flags.offset & irq_enable.offset)
		| (match_flags.phase  & irq_enable.phase)
		| (match_flags.duty   & irq_enable.duty)
		| (match_flags.period & irq_enable.period);

	////////////////////////////////////////////////////////////////////////////
	// read data, captured in the setup cycle

	logic [`PWM_DATA_W-1:0] next_prdata;

	always_comb begin
		next_prdata = prdata;
		if (setup && !pwrite) begin
			next_prdata = `PWM_RST_WORD;
			if (hit_enable) begin
				next_prdata[`PWM_FLAG_N-1:0] = irq_enable;
			end else if (hit_flags) begin
				next_prdata[`PWM_FLAG_N-1:0] = match_flags;
			end else if (hit_ctrl) begin
				next_prdata[`PWM_BIT_MODULE_EN] = module_enable;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `PWM_RST_WORD;
		end else begin
			prdata <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	phase_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_enable.phase && match_flags.phase) |-> irq)
		else $error("phase flag enabled but no irq");

	duty_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_enable.duty && match_flags.duty) |-> irq)
		else $error("duty flag enabled but no irq");

	period_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_enable.period && match_flags.period) |-> irq)
		else $error("period flag enabled but no irq");

	offset_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_enable.offset && match_flags.offset) |-> irq)
		else $error("offset flag enabled but no irq");

	irq_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		((match_flags & irq_enable) == `PWM_RST_FLAGS) |-> !irq)
		else $error("irq without enabled flag");

	offset_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && match_event.offset) |=> match_flags.offset)
		else $error("offset match did not set flag");

	phase_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && match_event.phase) |=> match_flags.phase)
		else $error("phase match did not set flag");

	duty_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && match_event.duty) |=> match_flags.duty)
		else $error("duty match did not set flag");

	period_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && match_event.period) |=> match_flags.period)
		else $error("period match did not set flag");

	flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && !flag_wr_en && match_flags.period)
		##1 (module_enable && !flag_wr_en) |-> match_flags.period)
		else $error("period flag lost without clear");

	flag_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && flag_wr_en && match_event == `PWM_RST_FLAGS)
		|=> (match_flags == $past(flag_write)))
		else $error("flag write not stored");

	disabled_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!module_enable) |=> (match_flags == `PWM_RST_FLAGS))
		else $error("flags not clear while disabled");

	high_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !pwrite && (hit_enable || hit_flags))
		|-> (prdata[`PWM_DATA_W-1:`PWM_FLAG_N] == '0))
		else $error("unimplemented bits read nonzero");

	reset_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> (irq_enable == `PWM_RST_FLAGS
			&& match_flags == `PWM_RST_FLAGS && !module_enable))
		else $error("registers not zero after reset");

	module_en_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_lane0 && hit_ctrl) |=> (module_enable == $past(pwdata[`PWM_BIT_MODULE_EN])))
		else $error("module enable write not taken");

	offset_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && flag_wr_en && !match_event.offset && !flag_write.offset) |=> !match_flags.offset)
		else $error("offset flag not cleared by write");

	phase_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && flag_wr_en && !match_event.phase && !flag_write.phase) |=> !match_flags.phase)
		else $error("phase flag not cleared by write");

	duty_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && flag_wr_en && !match_event.duty && !flag_write.duty) |=> !match_flags.duty)
		else $error("duty flag not cleared by write");

	period_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && flag_wr_en && !match_event.period && !flag_write.period) |=> !match_flags.period)
		else $error("period flag not cleared by write");

	offset_force_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && flag_wr_en && flag_write.offset) |=> match_flags.offset)
		else $error("offset flag not set by write");

	phase_force_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && flag_wr_en && flag_write.phase) |=> match_flags.phase)
		else $error("phase flag not set by write");

	duty_force_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && flag_wr_en && flag_write.duty) |=> match_flags.duty)
		else $error("duty flag not set by write");

	period_force_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && flag_wr_en && flag_write.period) |=> match_flags.period)
		else $error("period flag not set by write");

	offset_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && match_event.offset && flag_wr_en) |=> match_flags.offset)
		else $error("offset event lost to write");

	phase_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && match_event.phase && flag_wr_en) |=> match_flags.phase)
		else $error("phase event lost to write");

	duty_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && match_event.duty && flag_wr_en) |=> match_flags.duty)
		else $error("duty event lost to write");

	period_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && match_event.period && flag_wr_en) |=> match_flags.period)
		else $error("period event lost to write");

	offset_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!module_enable && match_event.offset) |=> !match_flags.offset)
		else $error("offset event taken while disabled");

	phase_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!module_enable && match_event.phase) |=> !match_flags.phase)
		else $error("phase event taken while disabled");

	duty_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!module_enable && match_event.duty) |=> !match_flags.duty)
		else $error("duty event taken while disabled");

	period_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!module_enable && match_event.period) |=> !match_flags.period)
		else $error("period event taken while disabled");

	offset_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && !flag_wr_en && match_flags.offset) ##1 (module_enable && !flag_wr_en) |-> match_flags.offset)
		else $error("offset flag lost without clear");

	phase_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && !flag_wr_en && match_flags.phase) ##1 (module_enable && !flag_wr_en) |-> match_flags.phase)
		else $error("phase flag lost without clear");

	duty_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(module_enable && !flag_wr_en && match_flags.duty) ##1 (module_enable && !flag_wr_en) |-> match_flags.duty)
		else $error("duty flag lost without clear");

	ready_high_a: assert property (@(posedge pclk) disable iff (!presetn)
		access |-> pready)
		else $error("access without ready");

	err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !mapped) |-> pslverr)
		else $error("unmapped access without error");

	err_mapped_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access && mapped) |-> !pslverr)
		else $error("mapped access flagged as error");

	rd_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_enable) |=> (prdata[`PWM_FLAG_N-1:0] == $past(irq_enable)))
		else $error("enable read data wrong");

	rd_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_flags) |=> (prdata[`PWM_FLAG_N-1:0] == $past(match_flags)))
		else $error("flag read data wrong");

	rd_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_ctrl) |=> (prdata[`PWM_BIT_MODULE_EN] == $past(module_enable)))
		else $error("control read data wrong");

	rd_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && !mapped) |=> (prdata == `PWM_RST_WORD))
		else $error("unmapped read data nonzero");

	en_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_lane0 && hit_enable) |=> (irq_enable == $past(flag_write)))
		else $error("enable write not stored");

	en_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_lane0 && hit_enable) |=> $stable(irq_enable))
		else $error("enable changed without write");

	strobe_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && !pstrb[0]) |=> ($stable(irq_enable) && $stable(module_enable)))
		else $error("write without lane strobe taken");

	ctrl_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_lane0 && hit_ctrl) |=> $stable(module_enable))
		else $error("module enable changed without write");

	disabled_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!module_enable && flag_wr_en) |=> (match_flags == `PWM_RST_FLAGS))
		else $error("flag write taken while disabled");

	irq_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_enable == `PWM_RST_FLAGS) |-> !irq)
		else $error("irq with all enables off");

	irq_flagless_a: assert property (@(posedge pclk) disable iff (!presetn)
		(match_flags == `PWM_RST_FLAGS) |-> !irq)
		else $error("irq with no flag set");

	unmapped_nowr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && !mapped) |=> ($stable(irq_enable) && $stable(module_enable)))
		else $error("unmapped write changed a register");

endmodule

`default_nettype wire

// ---- rtl/pwm_irq_cfg.svh ----
/*
 * constants of the pwm match interrupt block: register offsets,
 * field positions and reset values.
 * assumes byte addressing on a 32-bit apb bus, one register per word.
 */
`ifndef PWM_IRQ_CFG_SVH
`define PWM_IRQ_CFG_SVH

`define PWM_ADDR_W        12
`define PWM_DATA_W        32
`define PWM_REG_W         8
`define PWM_FLAG_N        4
`define PWM_OFF_ENABLE    12'h000
`define PWM_OFF_FLAGS     12'h004
`define PWM_OFF_CTRL      12'h008
`define PWM_BIT_PERIOD    0
`define PWM_BIT_DUTY      1
`define PWM_BIT_PHASE     2
`define PWM_BIT_OFFSET    3
`define PWM_BIT_MODULE_EN 7
`define PWM_RST_REG       8'h00
`define PWM_RST_FLAGS     4'h0
`define PWM_RST_WORD      32'h0000_0000

`endif

// ---- rtl/pwm_irq_pkg.sv ----
/*
 * types of the pwm match interrupt block.
 * assumes pwm_irq_cfg.svh for widths.
 */
`include "pwm_irq_cfg.svh"

package pwm_irq_pkg;

	// one bit per match source, in flag register order
	typedef struct packed {
		logic offset;
		logic phase;
		logic duty;
		logic period;
	} match_bits_s;

	typedef logic [`PWM_REG_W-1:0] reg_byte_t;

endpackage

// ---- rtl/sticky_flag.sv ----
/*
 * one sticky interrupt flag: hardware set, software write, forced clear.
 * assumes set and write come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_irq_cfg.svh"

module sticky_flag (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic hold_clear,
	input  wire logic set_event,
	input  wire logic write_en,
	input  wire logic write_value,
	output var  logic flag
);

	logic next_flag;

	always_comb begin
		next_flag = flag;
		if (hold_clear) begin
			next_flag = 1'b0;
		end else if (set_event) begin
			next_flag = 1'b1;
		end else if (write_en) begin
			next_flag = write_value;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end

endmodule

`default_nettype wire

// ---- tb/pwm_core_model.sv ----
/*
 * pwm core stand-in: one-cycle match strobes on request.
 * assumes the bench raises req just after a pclk edge.
 */
`timescale 1ns/1ps
`default_nettype none

module pwm_core_model (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic [3:0]          req,
	output var  pwm_irq_pkg::match_bits_s match_event
);
	import pwm_irq_pkg::*;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			match_event <= '0;
		else
			match_event <= req;
	end
endmodule

`default_nettype wire

// ---- tb/tb_pwm_match_interrupt_logic.sv ----
/*
 * bench of the pwm match interrupt logic against an integer model.
 * assumes zero wait apb and strobes through pwm_core_model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_irq_cfg.svh"

module tb_pwm_match_interrupt_logic;
	import pwm_irq_pkg::*;

	logic        pclk, presetn, psel, penable, pwrite, slv;
	logic        pready, pslverr, module_enable, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, r;
	logic [3:0]  pstrb, req;
	match_bits_s match_event, match_flags;
	int          error_cnt, tests_run, en_m, fl_m, on_m, n, k;

	pwm_match_interrupt_logic pwm_match_interrupt_logic_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .match_event,
		.module_enable, .match_flags, .irq);
	pwm_core_model pwm_core_model_inst (.pclk, .presetn, .req, .match_event);

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic close_out();
		$display("errors=%0d checks=%0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			error_cnt++;
			close_out();
		end
		if (w && s[0] && a == `PWM_OFF_ENABLE)
			en_m = d & 32'hf;
		if (w && s[0] && a == `PWM_OFF_FLAGS && on_m != 0)
			fl_m = d & 32'hf;
		if (w && s[0] && a == `PWM_OFF_CTRL)
			on_m = d[7];
		if (on_m == 0)
			fl_m = 0;
	endtask

	task automatic rdchk(input logic [11:0] a, input int exp);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(rd, exp);
		chk(32'(slv), 32'h0);
	endtask

	task automatic pins();
		#1;
		chk(32'(match_flags), fl_m);
		chk(32'(irq), 32'(|(fl_m & en_m)));
		chk(32'(module_enable), on_m);
	endtask

	task automatic pulse(input logic [3:0] p);
		@(posedge pclk);
		req <= p;
		@(posedge pclk);
		req <= 4'h0;
		@(posedge pclk);
		if (on_m != 0)
			fl_m = fl_m | p;
		pins();
	endtask

	task automatic regs();
		rdchk(`PWM_OFF_ENABLE, en_m);
		rdchk(`PWM_OFF_FLAGS, fl_m);
		rdchk(`PWM_OFF_CTRL, on_m << 7);
		pins();
	endtask

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb, req} = '0;
		{error_cnt, tests_run, en_m, fl_m, on_m} = '0;
		void'($urandom(94));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		regs();
		apb(1'b1, `PWM_OFF_FLAGS, 32'hf, 4'hf);
		pulse(4'hf);
		regs();
		apb(1'b1, `PWM_OFF_ENABLE, 32'hffff_ffff, 4'hf);
		apb(1'b1, `PWM_OFF_CTRL, 32'h80, 4'hf);
		for (k = 0; k < 4; k++)
			pulse(4'h1 << k);
		regs();
		for (k = 0; k < 80; k++) begin
			r = $urandom;
			case (r[1:0])
				2'd0: pulse(r[7:4]);
				2'd1: apb(1'b1, `PWM_OFF_ENABLE, $urandom, r[7:4]);
				2'd2: apb(1'b1, `PWM_OFF_FLAGS, $urandom, r[7:4]);
				default: apb(1'b1, `PWM_OFF_CTRL, {24'h0, r[4] | r[5], 7'h0}, 4'hf);
			endcase
			regs();
		end
		apb(1'b1, 12'h00c, 32'hff, 4'hf);
		chk(32'(slv), 32'h1);
		apb(1'b0, 12'h00c, 32'h0, 4'h0);
		chk(rd, 32'h0);
		chk(32'(slv), 32'h1);
		apb(1'b1, `PWM_OFF_CTRL, 32'h80, 4'hf);
		apb(1'b1, `PWM_OFF_FLAGS, 32'hf, 4'hf);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		{en_m, fl_m, on_m} = '0;
		regs();
		close_out();
	end
endmodule

`default_nettype wire
